// *** test/nvm_array_model.sv ***
// Purpose: Array-side model counting pulse time of each operation
// Assumes: Tick and busy from the sequencer
// Notes:   Count cleared by the bench only before a fresh sequence
`timescale 1ns/1ps
`default_nettype none

module nvm_array_model (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_nrst,
    // Sequencer side
    input  wire logic i_busy,
    input  wire logic i_tick,
    input  wire logic i_clr,
    // Measurements
    output logic [15:0] o_ticks,
    output logic [7:0]  o_gap
);
    logic [7:0] since_reg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ticks   <= 16'h0000;
            o_gap     <= 8'h00;
            since_reg <= 8'h00;
        end else begin
            if (i_clr) o_ticks <= 16'h0000;
            else if (i_busy && i_tick) o_ticks <= o_ticks + 16'h0001;
            since_reg <= i_tick ? 8'h01 : since_reg + 8'h01;
            if (i_tick) o_gap <= since_reg;
        end
    end
endmodule : nvm_array_model
`default_nettype wire

// *** test/nvm_seq_properties.sv ***
// Purpose: Port-level checks of the command sequencer
// Assumes: Bound to nvm_command_sequencer, one clock domain
// Notes:   Async active-low reset disables every check
`timescale 1ns/1ps
`default_nettype none

module nvm_seq_properties (
    // Clock and reset
    input wire logic       I_CORE_CLK,
    input wire logic       I_NRST,
    // Writes and conditions
    input wire logic       I_ARRAY_WR,
    input wire logic       I_CMD_WR,
    input wire logic [7:0] I_CMD_CODE,
    input wire logic       I_DEBUG_ACCESS,
    input wire logic       I_SECURED,
    input wire logic       I_STAT_WR,
    input wire logic       I_STOP,
    // Status
    input wire logic       O_CBEF,
    input wire logic       O_CCF,
    input wire logic       O_ACC_ERR,
    input wire logic       O_DIV_SET,
    input wire logic       O_BUSY
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);

    property p_arr_nodiv; I_ARRAY_WR && !O_DIV_SET |=> O_ACC_ERR; endproperty
    a_arr_nodiv: assert property (p_arr_nodiv) else $error("array write w/o divider");
    property p_arr_full; I_ARRAY_WR && !O_CBEF |=> O_ACC_ERR; endproperty
    a_arr_full: assert property (p_arr_full) else $error("array write, buffer full");
    property p_bad_code;
        I_CMD_WR && !(I_CMD_CODE inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47}) |=> O_ACC_ERR;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("bad code accepted");
    property p_sec_dbg;
        I_CMD_WR && I_DEBUG_ACCESS && I_SECURED
            && (I_CMD_CODE inside {8'h20, 8'h25, 8'h40, 8'h47}) |=> O_ACC_ERR;
    endproperty
    a_sec_dbg: assert property (p_sec_dbg) else $error("secured debug code accepted");
    property p_stop; O_BUSY && I_STOP |=> O_ACC_ERR && O_CCF && !O_BUSY; endproperty
    a_stop: assert property (p_stop) else $error("stop did not abort");
    property p_done; $fell(O_BUSY) |-> O_CCF; endproperty
    a_done: assert property (p_done) else $error("end without complete flag");
    property p_run; O_BUSY |-> !O_CCF; endproperty
    a_run: assert property (p_run) else $error("complete flag while running");
    property p_sticky; O_ACC_ERR && !I_STAT_WR |=> O_ACC_ERR; endproperty
    a_sticky: assert property (p_sticky) else $error("error flag lost");
    property p_blocked; O_ACC_ERR && !O_BUSY |=> !O_BUSY; endproperty
    a_blocked: assert property (p_blocked) else $error("started under error");

    c_stop: cover property (O_BUSY && I_STOP);
    c_abort_err: cover property ($fell(O_BUSY) && O_ACC_ERR);
    c_dbg: cover property (I_CMD_WR && I_DEBUG_ACCESS && I_SECURED);
endmodule : nvm_seq_properties
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the command sequencer
// Assumes: Divider 0, so one tick per core cycle
// Notes:   Row loop for commands, hand tests for errors
`timescale 1ns/1ps
`default_nettype none

module testbench;
    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] addr;
        logic [15:0] ticks;
        logic        err;
    } row_t;
    localparam int ARR = 0, CMD = 1, STAT = 2, DIV = 3, CTRL = 4;

    logic core_clk = 1'b0, nrst = 1'b0, clr = 1'b0, dbg = 1'b0, stop = 1'b0;
    logic arr_wr = 1'b0, cmd_wr = 1'b0, st_wr = 1'b0, div_wr = 1'b0, ctrl_wr = 1'b0;
    logic secured = 1'b0, prot = 1'b0, st_cbef = 1'b0, st_acc = 1'b0;
    logic [15:0] arr_addr = 16'h0000;
    logic [7:0]  cmd_code = 8'h00;
    logic [9:0]  div_val  = 10'h000;
    logic        cbef, ccf, acc_err, div_set, hv, busy, tick;
    logic [15:0] ticks, op_addr;
    logic [7:0]  gap, op_code, op_data;
    int          err_count = 0;
    int          checks    = 0;
    int          cyc       = 0;
    row_t        rows [8]  = '{'{8'h05, 16'h0010, 16'h0009, 1'b0}, '{8'h20, 16'h0011, 16'h0009, 1'b0},
        '{8'h25, 16'h0012, 16'h0009, 1'b0}, '{8'h40, 16'h0200, 16'h0FA0, 1'b0},
        '{8'h41, 16'h0300, 16'h4E20, 1'b0}, '{8'h47, 16'h0000, 16'h0004, 1'b0},
        '{8'h33, 16'h0013, 16'h0000, 1'b1}, '{8'hFF, 16'h0014, 16'h0000, 1'b1}};

    nvm_command_sequencer dut (.I_CORE_CLK(core_clk), .I_NRST(nrst), .I_ARRAY_WR(arr_wr),
        .I_ARRAY_ADDR(arr_addr), .I_ARRAY_DATA(arr_addr[7:0]), .I_CMD_WR(cmd_wr),
        .I_CMD_CODE(cmd_code), .I_DEBUG_ACCESS(dbg), .I_STAT_WR(st_wr), .I_STAT_CBEF(st_cbef),
        .I_STAT_ACC_ERR(st_acc), .I_DIV_WR(div_wr), .I_DIV_VALUE(div_val), .I_CTRL_WR(ctrl_wr),
        .I_STOP(stop), .I_SECURED(secured), .I_PROTECTED(prot), .O_CBEF(cbef), .O_CCF(ccf),
        .O_ACC_ERR(acc_err), .O_DIV_SET(div_set), .O_HV_EN(hv), .O_BUSY(busy), .O_TICK(tick),
        .O_OP_CODE(op_code), .O_OP_ADDR(op_addr), .O_OP_DATA(op_data));
    nvm_array_model far (.i_clk(core_clk), .i_nrst(nrst), .i_busy(busy), .i_tick(tick),
        .i_clr(clr), .o_ticks(ticks), .o_gap(gap));

    always #4 core_clk = ~core_clk;

    task automatic summarize;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            summarize();
        end
    end

    task automatic chk1(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %b seen %b", n, e, g);
            err_count++;
        end
    endtask : chk1

    task automatic chkn(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chkn

    // One write pulse of one cycle, driven between rising edges
    task automatic wr(input int k, input logic [15:0] v);
        @(negedge core_clk);
        arr_wr   = (k == ARR);
        cmd_wr   = (k == CMD);
        st_wr    = (k == STAT);
        div_wr   = (k == DIV);
        ctrl_wr  = (k == CTRL);
        arr_addr = v;
        cmd_code = v[7:0];
        st_cbef  = v[1];
        st_acc   = v[0];
        div_val  = v[9:0];
        @(negedge core_clk);
        {arr_wr, cmd_wr, st_wr, div_wr, ctrl_wr} = 5'h00;
    endtask : wr

    task automatic seq(input logic [7:0] c, input logic [15:0] a, input logic fresh);
        clr = fresh;
        wr(ARR, a);
        clr = 1'b0;
        wr(CMD, {8'h00, c});
        wr(STAT, 16'h0002);
    endtask : seq

    task automatic wait_done;
        int n;
        n = 0;
        while (!(ccf === 1'b1 && busy === 1'b0) && n < 30000) begin
            @(negedge core_clk);
            n++;
        end
    endtask : wait_done

    task automatic eseq(input int k, input logic [15:0] v);
        wr(ARR, 16'h0020);
        wr(k, v);
        chk1("acc_err", 1'b1, acc_err);
        wr(STAT, 16'h0001);
    endtask : eseq

    initial begin
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        chk1("cbef", 1'b1, cbef);
        chk1("ccf", 1'b1, ccf);
        chk1("acc_err", 1'b0, acc_err);
        chk1("div_set", 1'b0, div_set);
        wr(ARR, 16'h0010);
        chk1("acc_err", 1'b1, acc_err);
        wr(STAT, 16'h0001);
        chk1("acc_err", 1'b0, acc_err);
        wr(DIV, 16'h0000);
        wr(DIV, 16'h0005);
        for (int i = 0; i < 8; i++) begin
            seq(rows[i].code, rows[i].addr, 1'b1);
            wait_done();
            if (rows[i].ticks != 16'h0000) chkn("ticks", rows[i].ticks, ticks);
            chk1("row acc_err", rows[i].err, acc_err);
            if (rows[i].err) wr(STAT, 16'h0001);
        end
        chkn("tick gap", 16'h0001, {8'h00, gap});
        prot = 1'b1;
        seq(8'h41, 16'h0300, 1'b1);
        chk1("acc_err", 1'b1, acc_err);
        prot = 1'b0;
        wr(STAT, 16'h0001);
        secured = 1'b1;
        dbg = 1'b1;
        seq(8'h20, 16'h0030, 1'b1);
        chk1("acc_err", 1'b1, acc_err);
        wr(STAT, 16'h0001);
        seq(8'h05, 16'h0030, 1'b1);
        wait_done();
        chk1("acc_err", 1'b0, acc_err);
        {secured, dbg} = 2'b00;
        eseq(STAT, 16'h0000);
        eseq(ARR, 16'h0021);
        eseq(CTRL, 16'h0000);
        seq(8'h20, 16'h0040, 1'b1);
        chkn("op code", 16'h0020, {8'h00, op_code});
        chkn("op addr", 16'h0040, op_addr);
        chkn("op data", 16'h0040, {8'h00, op_data});
        chk1("hv on", 1'b1, hv);
        stop = 1'b1;
        @(negedge core_clk);
        stop = 1'b0;
        chk1("stop acc_err", 1'b1, acc_err);
        chk1("stop busy", 1'b0, busy);
        wr(STAT, 16'h0001);
        seq(8'h25, 16'h0040, 1'b1);
        seq(8'h25, 16'h0041, 1'b0);
        wait_done();
        chkn("burst", 16'h000D, ticks);
        chk1("burst acc_err", 1'b0, acc_err);
        chk1("hv off", 1'b0, hv);
        seq(8'h25, 16'h005F, 1'b1);
        seq(8'h25, 16'h0060, 1'b0);
        wait_done();
        chkn("new block", 16'h0012, ticks);
        seq(8'h40, 16'h0100, 1'b1);
        repeat (20) @(negedge core_clk);
        seq(8'h47, 16'h0000, 1'b0);
        chk1("abort cbef", 1'b0, cbef);
        wait_done();
        chk1("abort acc_err", 1'b1, acc_err);
        chk1("cut short", 1'b1, ticks < 16'h0040);
        wr(STAT, 16'h0001);
        seq(8'h40, 16'h0100, 1'b1);
        repeat (20) @(negedge core_clk);
        seq(8'h47, 16'h0000, 1'b0);
        wr(ARR, 16'h0200);
        chk1("abort new seq", 1'b1, acc_err);
        wait_done();
        // Abort lands with 3 ticks of erase left: erase ends normally
        wr(STAT, 16'h0001);
        seq(8'h40, 16'h0100, 1'b1);
        repeat (3992) @(negedge core_clk);
        seq(8'h47, 16'h0000, 1'b0);
        wait_done();
        chkn("late abort", 16'h0FA0, ticks);
        chk1("late abort acc_err", 1'b0, acc_err);
        summarize();
    end
endmodule : testbench

bind nvm_command_sequencer nvm_seq_properties props (.I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST),
    .I_ARRAY_WR(I_ARRAY_WR), .I_CMD_WR(I_CMD_WR), .I_CMD_CODE(I_CMD_CODE),
    .I_DEBUG_ACCESS(I_DEBUG_ACCESS), .I_SECURED(I_SECURED), .I_STAT_WR(I_STAT_WR),
    .I_STOP(I_STOP), .O_CBEF(O_CBEF), .O_CCF(O_CCF), .O_ACC_ERR(O_ACC_ERR),
    .O_DIV_SET(O_DIV_SET), .O_BUSY(O_BUSY));
`default_nettype wire

// *** verilog/nvm_command_sequencer.sv ***
// Purpose: Flash/EEPROM command sequencer with write-protocol checking.
// Assumes: All inputs synchronous to I_CORE_CLK; write strobes one cycle.
// Notes:   Timing clock tick every (divider + 1) core cycles.
`timescale 1ns/1ps
`default_nettype none

module nvm_command_sequencer (
    // Clock and reset
    input  wire logic                           I_CORE_CLK,
    input  wire logic                           I_NRST,
    // Array write
    input  wire logic                           I_ARRAY_WR,
    input  wire logic [nvm_seq_pkg::ADDR_W-1:0] I_ARRAY_ADDR,
    input  wire logic [nvm_seq_pkg::DATA_W-1:0] I_ARRAY_DATA,
    // Command register write
    input  wire logic                           I_CMD_WR,
    input  wire logic [7:0]                     I_CMD_CODE,
    input  wire logic                           I_DEBUG_ACCESS,
    // Status register write
    input  wire logic                           I_STAT_WR,
    input  wire logic                           I_STAT_CBEF,
    input  wire logic                           I_STAT_ACC_ERR,
    // Divider and other control writes
    input  wire logic                           I_DIV_WR,
    input  wire logic [nvm_seq_pkg::DIV_W-1:0]  I_DIV_VALUE,
    input  wire logic                           I_CTRL_WR,
    // System conditions
    input  wire logic                           I_STOP,
    input  wire logic                           I_SECURED,
    input  wire logic                           I_PROTECTED,
    // Status
    output logic                                O_CBEF,
    output logic                                O_CCF,
    output logic                                O_ACC_ERR,
    output logic                                O_DIV_SET,
    // Array operation
    output logic                                O_HV_EN,
    output logic                                O_BUSY,
    output logic                                O_TICK,
    output logic [7:0]                          O_OP_CODE,
    output logic [nvm_seq_pkg::ADDR_W-1:0]      O_OP_ADDR,
    output logic [nvm_seq_pkg::DATA_W-1:0]      O_OP_DATA
);

    nvm_seq_pkg::state_t st_reg;
    nvm_seq_pkg::state_t st_next;

    function automatic logic code_valid(input logic [7:0] c);
        code_valid = (c == nvm_seq_pkg::CMD_BLANK) || (c == nvm_seq_pkg::CMD_BYTE)
                  || (c == nvm_seq_pkg::CMD_BURST) || (c == nvm_seq_pkg::CMD_SECTOR)
                  || (c == nvm_seq_pkg::CMD_MASS)  || (c == nvm_seq_pkg::CMD_ABORT);
    endfunction : code_valid

    // Standard duration of a fresh command in timing ticks
    function automatic logic [nvm_seq_pkg::CNT_W-1:0] base_ticks(input logic [7:0] c);
        case (c)
            nvm_seq_pkg::CMD_SECTOR: base_ticks = nvm_seq_pkg::TICKS_SECTOR; // see RULE2
            nvm_seq_pkg::CMD_MASS:   base_ticks = nvm_seq_pkg::TICKS_MASS;   // see RULE2
            nvm_seq_pkg::CMD_ABORT:  base_ticks = nvm_seq_pkg::TICKS_ABORT;  // see RULE3
            nvm_seq_pkg::CMD_BLANK:  base_ticks = nvm_seq_pkg::TICKS_BLANK;
            default:                 base_ticks = nvm_seq_pkg::TICKS_BYTE;   // see RULE2
        endcase
    endfunction : base_ticks

    logic launch_ok;
    logic secured_debug_bad;
    logic erase_active;
    logic finish;

    always_comb begin
        secured_debug_bad = I_DEBUG_ACCESS && I_SECURED
                         && ((I_CMD_CODE == nvm_seq_pkg::CMD_BYTE)
                          || (I_CMD_CODE == nvm_seq_pkg::CMD_BURST)
                          || (I_CMD_CODE == nvm_seq_pkg::CMD_SECTOR)
                          || (I_CMD_CODE == nvm_seq_pkg::CMD_ABORT));
        erase_active = (st_reg.exec == nvm_seq_pkg::EX_RUN)
                    && (st_reg.cur.code == nvm_seq_pkg::CMD_SECTOR);
        finish = (st_reg.exec == nvm_seq_pkg::EX_RUN) && st_reg.tick
              && (st_reg.remain == nvm_seq_pkg::CNT_W'(1));
        launch_ok = I_STAT_WR && I_STAT_CBEF && (st_reg.seq == nvm_seq_pkg::SEQ_CMD)
                 && !st_reg.acc_err;                                   // see RULE17
    end

    always_comb begin
        logic set_err;
        logic start_pend;
        logic same_burst;
        set_err    = 1'b0;
        start_pend = 1'b0;
        same_burst = 1'b0;
        st_next    = st_reg;

        // Timing clock prescaler, idle until the divider is set
        st_next.tick = 1'b0;
        if (st_reg.div_set) begin
            if (st_reg.presc == st_reg.div_val) begin
                st_next.presc = '0;
                st_next.tick  = 1'b1;
            end else begin
                st_next.presc = st_reg.presc + nvm_seq_pkg::DIV_W'(1);
            end
        end

        // Divider: one write only, before any sequence
        if (I_DIV_WR && !st_reg.div_set) begin
            if (st_reg.seq != nvm_seq_pkg::SEQ_IDLE) begin
                set_err = 1'b1;                                        // see RULE19
            end else begin
                st_next.div_set = 1'b1;                                // see RULE1
                st_next.div_val = I_DIV_VALUE;
            end
        end else if (I_DIV_WR && st_reg.seq != nvm_seq_pkg::SEQ_IDLE) begin
            set_err = 1'b1;                                            // see RULE19
        end

        // Other control register written mid-sequence
        if (I_CTRL_WR && st_reg.seq != nvm_seq_pkg::SEQ_IDLE) begin
            set_err = 1'b1;                                            // see RULE19
        end

        // Step one: array write latches address and data
        if (I_ARRAY_WR) begin
            if (!st_reg.div_set || !st_reg.cbef || st_reg.acc_err
                || st_reg.seq != nvm_seq_pkg::SEQ_IDLE) begin
                set_err = 1'b1;                                        // see RULE18, RULE16, RULE19
            end else begin
                st_next.seq        = nvm_seq_pkg::SEQ_ADDR;            // see RULE4
                st_next.latch.addr = I_ARRAY_ADDR;
                st_next.latch.data = I_ARRAY_DATA;
            end
        end

        // Step two: command code into the command buffer
        if (I_CMD_WR) begin
            if (st_reg.seq != nvm_seq_pkg::SEQ_ADDR || !code_valid(I_CMD_CODE)
                || secured_debug_bad) begin
                set_err = 1'b1;                                        // see RULE19, RULE20, RULE22
            end else begin
                st_next.seq        = nvm_seq_pkg::SEQ_CMD;             // see RULE5, RULE6
                st_next.latch.code = I_CMD_CODE;
            end
        end

        // Status write: cancel, out-of-order launch, or error clear
        if (I_STAT_WR) begin
            if (!I_STAT_CBEF && st_reg.seq != nvm_seq_pkg::SEQ_IDLE) begin
                set_err = 1'b1;                                        // see RULE8
            end else if (I_STAT_CBEF && st_reg.seq == nvm_seq_pkg::SEQ_ADDR) begin
                set_err = 1'b1;                                        // see RULE19
            end
            if (I_STAT_ACC_ERR) begin
                st_next.acc_err = 1'b0;                                // see RULE17
            end
        end

        // Executor countdown and completion
        if (st_reg.exec == nvm_seq_pkg::EX_RUN && st_reg.tick && !finish) begin
            st_next.remain = st_reg.remain - nvm_seq_pkg::CNT_W'(1);
        end
        if (finish) begin
            if (st_reg.abort_hit) begin
                set_err = 1'b1;                                        // see RULE14
            end
            st_next.abort_hit = 1'b0;
            same_burst = st_reg.pend && st_reg.cur.code == nvm_seq_pkg::CMD_BURST
                      && st_reg.queued.code == nvm_seq_pkg::CMD_BURST;
            if (!same_burst) begin
                st_next.hv = 1'b0;                                     // see RULE12
            end
            if (st_reg.pend) begin
                start_pend = 1'b1;
            end else begin
                st_next.exec = nvm_seq_pkg::EX_IDLE;
                st_next.ccf  = 1'b1;                                   // see RULE9
                st_next.cbef = 1'b1;
            end
        end

        // Step three: launch
        if (launch_ok) begin
            st_next.seq  = nvm_seq_pkg::SEQ_IDLE;
            st_next.cbef = 1'b0;                                       // see RULE7
            st_next.ccf  = 1'b0;
            if (st_reg.latch.code == nvm_seq_pkg::CMD_MASS && I_PROTECTED) begin
                set_err      = 1'b1;                                   // see RULE10
                st_next.cbef = st_reg.cbef;
                st_next.ccf  = st_reg.ccf;
            end else if (st_reg.latch.code == nvm_seq_pkg::CMD_ABORT && erase_active
                         && !finish) begin                             // see RULE13
                // Abort shortens a running sector erase; buffer stays not-empty
                if (st_reg.remain > nvm_seq_pkg::TICKS_ABORT) begin
                    st_next.remain    = nvm_seq_pkg::TICKS_ABORT;      // see RULE3
                    st_next.abort_hit = 1'b1;                          // see RULE14
                end                                                    // see RULE15, RULE16
            end else if (st_reg.exec == nvm_seq_pkg::EX_IDLE || (finish && !st_reg.pend)) begin
                st_next.exec   = nvm_seq_pkg::EX_RUN;
                st_next.cur    = st_reg.latch;
                st_next.remain = base_ticks(st_reg.latch.code);        // see RULE12
                st_next.hv     = (st_reg.latch.code != nvm_seq_pkg::CMD_BLANK)
                              && (st_reg.latch.code != nvm_seq_pkg::CMD_ABORT);
                st_next.cbef   = (st_reg.latch.code != nvm_seq_pkg::CMD_ABORT);
            end else begin
                st_next.pend   = 1'b1;
                st_next.queued = st_reg.latch;
            end
        end

        // Queued command enters the executor
        if (start_pend) begin
            st_next.pend   = 1'b0;
            st_next.cur    = st_reg.queued;
            st_next.cbef   = (st_reg.queued.code != nvm_seq_pkg::CMD_ABORT);
            st_next.hv     = (st_reg.queued.code != nvm_seq_pkg::CMD_BLANK)
                          && (st_reg.queued.code != nvm_seq_pkg::CMD_ABORT);
            if (same_burst && st_reg.hv
                && st_reg.queued.addr[nvm_seq_pkg::ADDR_W-1:nvm_seq_pkg::BLOCK_LSB]
                   == st_reg.cur.addr[nvm_seq_pkg::ADDR_W-1:nvm_seq_pkg::BLOCK_LSB]) begin
                st_next.remain = nvm_seq_pkg::TICKS_BURST;             // see RULE11, RULE3
            end else begin
                st_next.remain = base_ticks(st_reg.queued.code);       // see RULE12
            end
        end

        // Stop mode kills a running operation
        if (I_STOP && st_reg.exec == nvm_seq_pkg::EX_RUN) begin
            set_err           = 1'b1;                                  // see RULE21
            st_next.exec      = nvm_seq_pkg::EX_IDLE;
            st_next.pend      = 1'b0;
            st_next.hv        = 1'b0;
            st_next.abort_hit = 1'b0;
            st_next.ccf       = 1'b1;
            st_next.cbef      = 1'b1;
        end

        // Any error drops a partial sequence; set beats clear
        if (set_err) begin
            st_next.acc_err = 1'b1;                                    // see RULE17
            if (!launch_ok) begin
                st_next.seq = nvm_seq_pkg::SEQ_IDLE;                   // see RULE8
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_reg.div_set   <= 1'b0;                                  // see RULE23
            st_reg.div_val   <= '0;
            st_reg.presc     <= '0;
            st_reg.cbef      <= 1'b1;
            st_reg.ccf       <= 1'b1;
            st_reg.acc_err   <= 1'b0;
            st_reg.seq       <= nvm_seq_pkg::SEQ_IDLE;
            st_reg.latch     <= nvm_seq_pkg::OP_RESET;
            st_reg.pend      <= 1'b0;
            st_reg.queued    <= nvm_seq_pkg::OP_RESET;
            st_reg.exec      <= nvm_seq_pkg::EX_IDLE;
            st_reg.cur       <= nvm_seq_pkg::OP_RESET;
            st_reg.remain    <= '0;
            st_reg.hv        <= 1'b0;
            st_reg.abort_hit <= 1'b0;
            st_reg.tick      <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs are fields of the state register
    assign O_CBEF    = st_reg.cbef;
    assign O_CCF     = st_reg.ccf;
    assign O_ACC_ERR = st_reg.acc_err;
    assign O_DIV_SET = st_reg.div_set;
    assign O_HV_EN   = st_reg.hv;
    assign O_BUSY    = st_reg.exec[0];  // Only the run code has bit 0 set
    assign O_TICK    = st_reg.tick;
    assign O_OP_CODE = st_reg.cur.code;
    assign O_OP_ADDR = st_reg.cur.addr;
    assign O_OP_DATA = st_reg.cur.data;

endmodule : nvm_command_sequencer

`default_nettype wire

// *** verilog/nvm_seq_pkg.sv ***
// Purpose: Shared constants and types for the flash/EEPROM command sequencer.
// Assumes: Core clock of 125 MHz; timing clock made by an integer divider.
// Notes:   Command codes, tick counts and the state record live here.
//
// What this block does
// RULE1: Divider written once, before any command accepted
// RULE2: Byte 9, sector 4000, mass 20000 ticks
// RULE3: Burst follow-on byte and abort take 4 ticks
// RULE4: Array write latches address and data first
// RULE5: Accept blank check, byte and burst program codes
// RULE6: Accept sector erase, mass erase, abort codes
// RULE7: Writing one to buffer-empty launches command
// RULE8: Writing zero mid-sequence cancels, sets access error
// RULE9: Complete flag sets when operation finishes
// RULE10: Mass erase only when nothing is protected
// RULE11: Burst keeps high voltage if queued, same block
// RULE12: First or new-block byte takes standard time
// RULE13: Abort: array write, code, then launch
// RULE14: Abort cutting erase short sets error at completion
// RULE15: Erase finishing normally under abort sets no error
// RULE16: No buffer-empty after abort; new sequence errors
// RULE17: Access error cleared by one; blocks commands
// RULE18: Array write errors without divider or buffer-empty
// RULE19: Second write or stray control write errors
// RULE20: Unknown command code sets access error
// RULE21: Stop during program or erase aborts with error
// RULE22: Secured debug may only blank check, mass erase
// RULE23: Reset clears sequence state, leaves block idle
package nvm_seq_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int DIV_W  = 10;
    localparam int CNT_W  = 15;
    localparam int BLOCK_LSB = 5;

    // Timing clock window and core clock
    localparam int CORE_CLK_HZ   = 125_000_000;
    localparam int TCLK_MIN_HZ   = 150_000;
    localparam int TCLK_MAX_HZ   = 200_000;
    localparam int DIV_FOR_MAX   = (CORE_CLK_HZ + TCLK_MAX_HZ - 1) / TCLK_MAX_HZ - 1;

    localparam logic [7:0] CMD_BLANK   = 8'h05;
    localparam logic [7:0] CMD_BYTE    = 8'h20;
    localparam logic [7:0] CMD_BURST   = 8'h25;
    localparam logic [7:0] CMD_SECTOR  = 8'h40;
    localparam logic [7:0] CMD_MASS    = 8'h41;
    localparam logic [7:0] CMD_ABORT   = 8'h47;

    localparam logic [CNT_W-1:0] TICKS_BYTE   = 15'h0009;
    localparam logic [CNT_W-1:0] TICKS_BURST  = 15'h0004;
    localparam logic [CNT_W-1:0] TICKS_SECTOR = 15'h0FA0;
    localparam logic [CNT_W-1:0] TICKS_MASS   = 15'h4E20;
    localparam logic [CNT_W-1:0] TICKS_ABORT  = 15'h0004;
    localparam logic [CNT_W-1:0] TICKS_BLANK  = 15'h0009;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ADDR = 2'b01,
        SEQ_CMD  = 2'b10
    } seq_t;

    typedef enum logic [1:0] {
        EX_IDLE = 2'b00,
        EX_RUN  = 2'b01
    } exec_t;

    typedef struct packed {
        logic [7:0]        code;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } op_t;

    localparam op_t OP_RESET = '{code: 8'h00, addr: 16'h0000, data: 8'h00};

    typedef struct packed {
        logic              div_set;
        logic [DIV_W-1:0]  div_val;
        logic [DIV_W-1:0]  presc;
        logic              cbef;
        logic              ccf;
        logic              acc_err;
        seq_t              seq;
        op_t               latch;
        logic              pend;
        op_t               queued;
        exec_t             exec;
        op_t               cur;
        logic [CNT_W-1:0]  remain;
        logic              hv;
        logic              abort_hit;
        logic              tick;
    } state_t;

endpackage : nvm_seq_pkg
